// file: core/atmtx_cell_proc.sv
// Transmit ATM cell processor: four-cell FIFO, idle fill, HCS, GFC insert, scrambler.
// Assumes the ATM layer writes on tx_fifo_clock and the line side pulls bytes on clk.
`timescale 1ns/100ps
module atmtx_cell_proc
	import atmtx_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic tx_fifo_clock,
	input wire logic [7:0] tx_byte_bus,
	input wire logic tx_write_enable_n,
	input wire logic tx_cell_start_mark,
	output logic tx_cell_available,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic line_byte_req,
	input wire logic gfc_serial_in,
	input wire logic gfc_frame_pulse,
	output logic [7:0] line_byte,
	output logic line_byte_valid,
	output logic line_cell_start,
	output logic line_cell_assigned,
	output logic [IDX_W-1:0] h4_offset,
	output logic tx_irq
);
	import atmtx_pkg::*;

	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CELL_BYTES - 1);
	localparam logic [IDX_W-1:0] EARLY_IDX = IDX_W'(CELL_BYTES - EARLY_OCTETS);
	localparam logic [IDX_W-1:0] HCS_IDX = IDX_W'(HCS_POS);
	localparam logic [PTR_W-1:0] FULL_CNT = PTR_W'(FIFO_CELLS);

	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b = g;
		for (int i = PTR_W - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	function automatic logic [MEM_AW-1:0] mem_addr(input logic [PTR_W-1:0] p,
		input logic [IDX_W-1:0] i);
		return MEM_AW'(p[PTR_W-2:0]) * MEM_AW'(CELL_BYTES) + MEM_AW'(i);
	endfunction

	// Cell storage, written on the link clock and read on clk once a cell is committed
	logic [7:0] cell_mem [0:FIFO_CELLS*CELL_BYTES-1];

	// Registers in the clk domain
	logic [7:0] master_cfg_reg, ctrl_reg, idle_hdr_reg, idle_pay_reg, fifo_cfg_reg, cell_cfg_reg;
	logic ovr_reg, ovr_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next, cnt_hold_reg;
	logic [7:0] rdata_next;
	logic irq_next;

	// Link-side state
	logic [IDX_W-1:0] widx_reg, widx_next;
	logic [PTR_W-1:0] wptr_reg, wptr_next, wgray_reg;
	logic wbusy_reg, wbusy_next;
	logic ovr_tog_reg, ovr_tog_next;
	logic tca_reg, tca_next;
	logic [PTR_W-1:0] w_rg1_reg, w_rg2_reg;
	logic [3:0] w_cfg1_reg, w_cfg2_reg;
	logic mem_we;
	logic [PTR_W-1:0] used_w;
	logic full_w;

	// Line-side state
	logic [PTR_W-1:0] r_wg1_reg, r_wg2_reg, rptr_reg, rptr_next, rgray_reg;
	logic [IDX_W-1:0] ridx_reg, ridx_next;
	logic assigned_reg, assigned_next;
	logic [7:0] hcs_reg, hcs_next;
	logic [SCR_LEN-1:0] scr_reg, scr_next;
	logic [7:0] obyte_next;
	logic ovr_s1_reg, ovr_s2_reg, ovr_s3_reg;
	logic gfc_d1_reg, gfc_d2_reg, frm_d1_reg, frm_d2_reg;
	logic [GFC_BITS-1:0] gfc_sh_reg, gfc_sh_next, gfc_cap_reg, gfc_cap_next;
	logic [2:0] gfc_cnt_reg, gfc_cnt_next;
	logic [IDX_W-1:0] h4_next;

	// Link side: accept bytes, commit whole cells, drive availability
	always_comb
	begin
		logic [PTR_W-1:0] rptr_w;
		logic [PTR_W-1:0] depth;
		logic early_hit;
		depth = '0;
		early_hit = 1'b0;
		rptr_w = gray2bin(w_rg2_reg);
		used_w = wptr_reg - rptr_w;
		full_w = (used_w == FULL_CNT);
		widx_next = widx_reg;
		wptr_next = wptr_reg;
		wbusy_next = wbusy_reg;
		ovr_tog_next = ovr_tog_reg;
		mem_we = 1'b0;
		if (!tx_write_enable_n)
		begin
			if (tx_cell_start_mark)
			begin
				if (full_w)
				begin
					ovr_tog_next = ~ovr_tog_reg;
					wbusy_next = 1'b0; // Rest of the cell is dropped
					widx_next = '0;
				end
				else
				begin
					mem_we = 1'b1;
					wbusy_next = 1'b1;
					widx_next = IDX_W'(1);
				end
			end
			else if (wbusy_reg)
			begin
				mem_we = 1'b1;
				widx_next = widx_reg + IDX_W'(1);
				if (widx_reg == LAST_IDX)
				begin
					wptr_next = wptr_reg + PTR_W'(1); // Cell commits on its last byte
					wbusy_next = 1'b0;
					widx_next = '0;
				end
			end
		end
		// Depth code 0 means four cells, 1..3 mean that many
		depth = (w_cfg2_reg[1:0] == 2'b00) ? FULL_CNT : PTR_W'(w_cfg2_reg[1:0]);
		early_hit = w_cfg2_reg[2] && wbusy_reg && (widx_reg >= EARLY_IDX);
		// Reads only free room at cell ends, so availability rises there
		tca_next = ((used_w + PTR_W'(early_hit)) < depth) ^ w_cfg2_reg[3];
	end

	// Link-side registers; the read pointer and static config pass two flops first
	always_ff @(posedge tx_fifo_clock or negedge resetn)
	begin
		if (!resetn)
		begin
			widx_reg <= '0;
			wptr_reg <= '0;
			wgray_reg <= '0;
			wbusy_reg <= 1'b0;
			ovr_tog_reg <= 1'b0;
			tca_reg <= 1'b0;
			w_rg1_reg <= '0;
			w_rg2_reg <= '0;
			w_cfg1_reg <= '0;
			w_cfg2_reg <= '0;
		end
		else
		begin
			widx_reg <= widx_next;
			wptr_reg <= wptr_next;
			wgray_reg <= bin2gray(wptr_next);
			wbusy_reg <= wbusy_next;
			ovr_tog_reg <= ovr_tog_next;
			tca_reg <= tca_next;
			w_rg1_reg <= rgray_reg;
			w_rg2_reg <= w_rg1_reg;
			w_cfg1_reg <= {master_cfg_reg[MCFG_TX_AVAIL_POLARITY_INVERT_BIT], fifo_cfg_reg[FCFG_EARLY_BIT],
				fifo_cfg_reg[FCFG_DEPTH_LSB+1:FCFG_DEPTH_LSB]};
			w_cfg2_reg <= w_cfg1_reg;
		end
	end

	// Storage write port, no reset needed on data
	always_ff @(posedge tx_fifo_clock)
	begin
		if (mem_we)
			cell_mem[mem_addr(wptr_reg, tx_cell_start_mark ? '0 : widx_reg)] <= tx_byte_bus;
	end

	// Line side: pick assigned or idle cell, add GFC and HCS, scramble payload
	always_comb
	begin
		logic [7:0] src;
		logic [7:0] b;
		logic [3:0] gdef;
		logic [SCR_LEN-1:0] h;
		logic use_cell;
		gdef = '0;
		h = '0;
		rptr_next = rptr_reg;
		ridx_next = ridx_reg;
		assigned_next = assigned_reg;
		hcs_next = hcs_reg;
		scr_next = scr_reg;
		cnt_next = cnt_reg;
		obyte_next = line_byte;
		h4_next = (ridx_reg == '0) ? '0 : IDX_W'(CELL_BYTES) - ridx_reg;
		use_cell = (ridx_reg == '0) ? (rptr_reg != gray2bin(r_wg2_reg)) : assigned_reg;
		src = cell_mem[mem_addr(rptr_reg, ridx_reg)];
		b = src;
		if (!use_cell)
		begin
			unique case (ridx_reg)
				IDX_W'(0): b = {idle_hdr_reg[7:IHDR_GFC_LSB], 4'h0};
				IDX_W'(1), IDX_W'(2): b = 8'h00;
				IDX_W'(3): b = {4'h0, idle_hdr_reg[IHDR_PTI_CLP_W-1:0]};
				default: b = idle_pay_reg;
			endcase
		end
		h = scr_reg;
		if (ridx_reg == '0)
		begin
			gdef = b[7:4];
			for (int i = 0; i < GFC_BITS; i++)
				b[4+i] = fifo_cfg_reg[FCFG_GFC_EN_LSB+i] ? gfc_cap_reg[i] : gdef[i];
		end
		if (ridx_reg < IDX_W'(HDR_CRC_BYTES))
			hcs_next = hcs_byte((ridx_reg == '0) ? 8'h00 : hcs_reg, b);
		else if (ridx_reg == HCS_IDX)
			b = hcs_reg ^ HCS_COSET;
		else if (!cell_cfg_reg[CCFG_SCR_DIS_BIT]) // Header octets never reach here
		begin
			for (int i = 7; i >= 0; i--)
			begin
				b[i] = b[i] ^ h[SCR_LEN-1]; // Self-synchronous x^43+1
				h = {h[SCR_LEN-2:0], b[i]};
			end
		end
		if (line_byte_req)
		begin
			obyte_next = b;
			assigned_next = use_cell;
			scr_next = h;
			ridx_next = ridx_reg + IDX_W'(1);
			if (ridx_reg == LAST_IDX)
			begin
				ridx_next = '0;
				if (use_cell)
				begin
					rptr_next = rptr_reg + PTR_W'(1);
					cnt_next = cnt_reg + CNT_W'(1);
				end
			end
		end
		else
			hcs_next = hcs_reg;
	end

	// Serial GFC capture: frame pulse marks the first of four bits, MSB first
	always_comb
	begin
		gfc_sh_next = gfc_sh_reg;
		gfc_cnt_next = gfc_cnt_reg;
		gfc_cap_next = gfc_cap_reg;
		if (frm_d2_reg || (gfc_cnt_reg != 3'h0 && gfc_cnt_reg < 3'(GFC_BITS)))
		begin
			gfc_sh_next = {gfc_sh_reg[GFC_BITS-2:0], gfc_d2_reg};
			gfc_cnt_next = frm_d2_reg ? 3'h1 : gfc_cnt_reg + 3'h1;
		end
		if (gfc_cnt_reg == 3'(GFC_BITS))
		begin
			gfc_cap_next = gfc_sh_reg; // Holds until the next frame completes
			gfc_cnt_next = 3'h0;
		end
	end

	// Register port: overrun sticky until status read, event wins a same-cycle read
	always_comb
	begin
		logic ovr_evt;
		logic [7:0] idx;
		ovr_evt = ovr_s2_reg ^ ovr_s3_reg;
		ovr_next = ovr_evt || (ovr_reg && !(reg_rd && reg_addr == ADDR_CTRL_STATUS));
		irq_next = ovr_next && ctrl_reg[CS_OVR_EN_BIT];
		idx = reg_addr;
		unique case (idx)
			ADDR_MASTER_CFG: rdata_next = master_cfg_reg;
			ADDR_CTRL_STATUS: rdata_next = {ctrl_reg[7:1], ovr_reg};
			ADDR_IDLE_HDR: rdata_next = idle_hdr_reg;
			ADDR_IDLE_PAYLOAD: rdata_next = idle_pay_reg;
			ADDR_FIFO_CFG: rdata_next = fifo_cfg_reg;
			ADDR_CNT_LOW: rdata_next = cnt_hold_reg[7:0];
			ADDR_CNT_MID: rdata_next = cnt_hold_reg[15:8];
			ADDR_CNT_HIGH: rdata_next = cnt_hold_reg[23:16];
			ADDR_CELL_CFG: rdata_next = cell_cfg_reg;
			default: rdata_next = 8'h00;
		endcase
		if (!reg_rd)
			rdata_next = reg_rdata;
	end

	// Line-side and register-side flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{r_wg1_reg, r_wg2_reg, rptr_reg, rgray_reg} <= '0;
			ridx_reg <= '0;
			assigned_reg <= 1'b0;
			hcs_reg <= '0;
			scr_reg <= '0;
			{line_byte, h4_offset} <= '0;
			{line_byte_valid, line_cell_start, line_cell_assigned} <= '0;
			{ovr_s1_reg, ovr_s2_reg, ovr_s3_reg, ovr_reg, tx_irq} <= '0;
			{gfc_d1_reg, gfc_d2_reg, frm_d1_reg, frm_d2_reg} <= '0;
			{gfc_sh_reg, gfc_cap_reg, gfc_cnt_reg} <= '0;
			{cnt_reg, cnt_hold_reg} <= '0;
			reg_rdata <= '0;
			{master_cfg_reg, ctrl_reg, idle_hdr_reg} <= {3{REG_RESET}};
			{idle_pay_reg, fifo_cfg_reg, cell_cfg_reg} <= {3{REG_RESET}};
		end
		else
		begin
			r_wg1_reg <= wgray_reg;
			r_wg2_reg <= r_wg1_reg; // Sync delay is part of the fill latency
			rptr_reg <= rptr_next;
			rgray_reg <= bin2gray(rptr_next);
			ridx_reg <= ridx_next;
			assigned_reg <= assigned_next;
			hcs_reg <= hcs_next;
			scr_reg <= scr_next;
			line_byte <= obyte_next;
			h4_offset <= h4_next;
			line_byte_valid <= line_byte_req;
			line_cell_start <= line_byte_req && (ridx_reg == '0);
			line_cell_assigned <= assigned_next;
			ovr_s1_reg <= ovr_tog_reg;
			ovr_s2_reg <= ovr_s1_reg;
			ovr_s3_reg <= ovr_s2_reg;
			ovr_reg <= ovr_next;
			tx_irq <= irq_next;
			gfc_d1_reg <= gfc_serial_in;
			gfc_d2_reg <= gfc_d1_reg;
			frm_d1_reg <= gfc_frame_pulse;
			frm_d2_reg <= frm_d1_reg;
			gfc_sh_reg <= gfc_sh_next;
			gfc_cnt_reg <= gfc_cnt_next;
			gfc_cap_reg <= gfc_cap_next;
			cnt_reg <= cnt_next;
			reg_rdata <= rdata_next;
			if (reg_wr && reg_addr == ADDR_MASTER_RESET)
				cnt_hold_reg <= cnt_next; // Snapshot for the readable holding bytes
			if (reg_wr && reg_addr == ADDR_MASTER_CFG)
				master_cfg_reg <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_CTRL_STATUS)
				ctrl_reg <= {reg_wdata[7:1], 1'b0};
			if (reg_wr && reg_addr == ADDR_IDLE_HDR)
				idle_hdr_reg <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_IDLE_PAYLOAD)
				idle_pay_reg <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_FIFO_CFG)
				fifo_cfg_reg <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_CELL_CFG)
				cell_cfg_reg <= reg_wdata;
		end
	end

	assign tx_cell_available = tca_reg;

	// Helper for checking: HCS recomputed from what actually left the block
	logic [7:0] chk_crc_reg;
	logic [IDX_W-1:0] chk_pos_reg;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			chk_crc_reg <= '0;
			chk_pos_reg <= '0;
		end
		else if (line_byte_req)
		begin
			chk_pos_reg <= ridx_reg;
			chk_crc_reg <= hcs_byte((ridx_reg == '0) ? 8'h00 : chk_crc_reg, obyte_next);
		end
	end

	a_fifo_bound: assert property (@(posedge tx_fifo_clock) disable iff (!resetn)
		used_w <= FULL_CNT) else $error("FIFO holds more than four cells");
	a_full_unavail: assert property (@(posedge tx_fifo_clock) disable iff (!resetn)
		full_w |=> tx_cell_available == w_cfg2_reg[3]) else $error("available while full");
	a_overrun_drop: assert property (@(posedge tx_fifo_clock) disable iff (!resetn)
		(full_w && !tx_write_enable_n && tx_cell_start_mark) |-> !mem_we ##1
		(ovr_tog_reg != $past(ovr_tog_reg))) else $error("write into full FIFO kept");
	a_idle_empty: assert property (@(posedge clk) disable iff (!resetn)
		(line_byte_req && ridx_reg == '0 && rptr_reg == gray2bin(r_wg2_reg)) |=>
		line_cell_start && !line_cell_assigned) else $error("idle cell not sent");
	a_idle_vpi_zero: assert property (@(posedge clk) disable iff (!resetn)
		(line_byte_req && !use_cell_c() && (ridx_reg == IDX_W'(1) || ridx_reg == IDX_W'(2)))
		|=> line_byte == 8'h00) else $error("idle VPI/VCI not zero");
	a_hcs_insert: assert property (@(posedge clk) disable iff (!resetn)
		(line_byte_valid && chk_pos_reg == IDX_W'(3)) ##1 (line_byte_req && ridx_reg == HCS_IDX)
		|=> line_byte == ($past(chk_crc_reg, 2) ^ HCS_COSET)) else $error("bad HCS");
	a_gfc_default: assert property (@(posedge clk) disable iff (!resetn)
		(line_byte_req && ridx_reg == '0 && !use_cell_c() && fifo_cfg_reg[7:4] == 4'h0)
		|=> line_byte[7:4] == $past(idle_hdr_reg[7:4])) else $error("GFC default wrong");
	a_ovr_sticky: assert property (@(posedge clk) disable iff (!resetn)
		(ovr_reg && !(reg_rd && reg_addr == ADDR_CTRL_STATUS)) |=> ovr_reg)
		else $error("overrun flag dropped without read");
	a_cnt_step: assert property (@(posedge clk) disable iff (!resetn)
		(cnt_reg != $past(cnt_reg)) |-> $past(line_byte_req && ridx_reg == LAST_IDX) &&
		line_cell_assigned) else $error("count moved off an assigned cell end");
	a_idle_payload: assert property (@(posedge clk) disable iff (!resetn)
		(line_byte_req && !use_cell_c() && ridx_reg > HCS_IDX && cell_cfg_reg[0])
		|=> line_byte == $past(idle_pay_reg)) else $error("idle payload wrong");

	c_assigned_cell: cover property (@(posedge clk) disable iff (!resetn)
		line_cell_start && line_cell_assigned);
	c_idle_cell: cover property (@(posedge clk) disable iff (!resetn)
		line_cell_start && !line_cell_assigned);
	c_overrun: cover property (@(posedge clk) disable iff (!resetn) $rose(ovr_reg));
	c_early_drop: cover property (@(posedge tx_fifo_clock) disable iff (!resetn)
		w_cfg2_reg[2] && wbusy_reg && widx_reg >= EARLY_IDX && $fell(tx_cell_available));

	function automatic logic use_cell_c();
		return (ridx_reg == '0) ? (rptr_reg != gray2bin(r_wg2_reg)) : assigned_reg;
	endfunction
endmodule

// file: core/atmtx_pkg.sv
// Constants shared by the transmit cell processor: geometry, register map, fields.
// Assumes a byte-wide register port in the system clock domain.
package atmtx_pkg;
	// Cell geometry and FIFO size
	localparam int CELL_BYTES = 53;
	localparam int HDR_CRC_BYTES = 4;
	localparam int HCS_POS = 4;
	localparam int FIFO_CELLS = 4;
	localparam int PTR_W = 3;
	localparam int IDX_W = 6;
	localparam int MEM_AW = 8;
	localparam int EARLY_OCTETS = 4;
	localparam int GFC_BITS = 4;
	localparam int SCR_LEN = 43;
	localparam int CNT_W = 24;
	// Header check generator and coset
	localparam logic [7:0] HCS_POLY = 8'h07;
	localparam logic [7:0] HCS_COSET = 8'h55;
	// Register offsets
	localparam logic [7:0] ADDR_MASTER_RESET = 8'h00;
	localparam logic [7:0] ADDR_MASTER_CFG = 8'h01;
	localparam logic [7:0] ADDR_CTRL_STATUS = 8'h60;
	localparam logic [7:0] ADDR_IDLE_HDR = 8'h61;
	localparam logic [7:0] ADDR_IDLE_PAYLOAD = 8'h62;
	localparam logic [7:0] ADDR_FIFO_CFG = 8'h63;
	localparam logic [7:0] ADDR_CNT_LOW = 8'h64;
	localparam logic [7:0] ADDR_CNT_MID = 8'h65;
	localparam logic [7:0] ADDR_CNT_HIGH = 8'h66;
	localparam logic [7:0] ADDR_CELL_CFG = 8'h67;
	// Field positions
	localparam int MCFG_TX_AVAIL_POLARITY_INVERT_BIT = 3;
	localparam int CS_OVR_BIT = 0;
	localparam int CS_OVR_EN_BIT = 1;
	localparam int FCFG_DEPTH_LSB = 0;
	localparam int FCFG_EARLY_BIT = 2;
	localparam int FCFG_GFC_EN_LSB = 4;
	localparam int CCFG_SCR_DIS_BIT = 0;
	localparam int IHDR_GFC_LSB = 4;
	localparam int IHDR_PTI_CLP_W = 4;
	// Reset value of every writable register
	localparam logic [7:0] REG_RESET = 8'h00;

	// One byte through the header CRC, most significant bit first
	function automatic logic [7:0] hcs_byte(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? HCS_POLY : 8'h00);
		return c;
	endfunction
endpackage

// file: dv/atmtx_writer_model.sv
// Behavioural ATM-layer writer: pushes one 53-byte cell per go request on the link clock.
// Assumes the bench raises go for one tx_fifo_clock cycle and then waits for busy to fall.
`timescale 1ns/100ps
module atmtx_writer_model
(
	input wire logic tx_fifo_clock,
	input wire logic resetn,
	input wire logic go,
	input wire logic [7:0] base,
	output logic [7:0] tx_byte_bus,
	output logic tx_write_enable_n,
	output logic tx_cell_start_mark,
	output logic busy
);
	int idx;
	logic [7:0] base_reg;

	// Cell bytes run base, base+1, ...; an idle bus flips every cycle between the inverse of the last byte and that byte
	always @(posedge tx_fifo_clock or negedge resetn)
	begin
		if (!resetn)
		begin
			idx <= 0;
			busy <= 1'b0;
			base_reg <= 8'h00;
			tx_byte_bus <= 8'h00;
			tx_write_enable_n <= 1'b1;
			tx_cell_start_mark <= 1'b0;
		end
		else if (go && !busy)
		begin
			base_reg <= base;
			tx_byte_bus <= base;
			tx_write_enable_n <= 1'b0;
			tx_cell_start_mark <= 1'b1;
			idx <= 1;
			busy <= 1'b1;
		end
		else if (busy && idx < 53)
		begin
			tx_byte_bus <= base_reg + 8'(idx);
			tx_cell_start_mark <= 1'b0;
			idx <= idx + 1;
		end
		else
		begin
			// Release: no stale byte left on the bus, so a late sample cannot pass by luck
			tx_byte_bus <= ~tx_byte_bus;
			tx_write_enable_n <= 1'b1;
			tx_cell_start_mark <= 1'b0;
			busy <= 1'b0;
		end
	end
endmodule

// file: dv/atm_tx_cell_processor_tb.sv
// Self-checking bench: register tasks, a link-clock writer model and a line-side puller.
// Assumes the register map and field positions of atmtx_pkg; line requests every 2 cycles.
`timescale 1ns/100ps
module atm_tx_cell_processor_tb;
	import atmtx_pkg::*;
	logic clk, resetn, tx_fifo_clock, go, reg_wr, reg_rd, line_byte_req;
	logic gfc_serial_in, gfc_frame_pulse, tx_write_enable_n, tx_cell_start_mark, busy;
	logic tx_cell_available, line_byte_valid, line_cell_start, line_cell_assigned, tx_irq;
	logic [7:0] base, reg_addr, reg_wdata, reg_rdata, line_byte, tx_byte_bus;
	logic [IDX_W-1:0] h4_offset;
	logic [42:0] scr;
	bit scr_on;
	int error_cnt, samples_checked;

	atmtx_writer_model atmtx_writer_model_i (.tx_fifo_clock(tx_fifo_clock), .resetn(resetn),
		.go(go), .base(base), .tx_byte_bus(tx_byte_bus), .tx_write_enable_n(tx_write_enable_n),
		.tx_cell_start_mark(tx_cell_start_mark), .busy(busy));
	atmtx_cell_proc atmtx_cell_proc_i (.clk(clk), .resetn(resetn), .tx_fifo_clock(tx_fifo_clock),
		.tx_byte_bus(tx_byte_bus), .tx_write_enable_n(tx_write_enable_n),
		.tx_cell_start_mark(tx_cell_start_mark), .tx_cell_available(tx_cell_available),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .line_byte_req(line_byte_req), .gfc_serial_in(gfc_serial_in),
		.gfc_frame_pulse(gfc_frame_pulse), .line_byte(line_byte),
		.line_byte_valid(line_byte_valid), .line_cell_start(line_cell_start),
		.line_cell_assigned(line_cell_assigned), .h4_offset(h4_offset), .tx_irq(tx_irq));

	// System clock 100 MHz, link clock 30 ns with an unrelated phase
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		tx_fifo_clock = 1'b0;
		#7;
		forever #15 tx_fifo_clock = ~tx_fifo_clock;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data is registered at the taking edge and holds until the next read
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata, e);
	endtask

	task automatic send_cell(input logic [7:0] b);
		@(posedge tx_fifo_clock);
		go <= 1'b1;
		base <= b;
		@(posedge tx_fifo_clock);
		go <= 1'b0;
		#1;
		for (int k = 0; k < 70 && busy; k++)
			@(posedge tx_fifo_clock);
		repeat (8) @(posedge clk);
	endtask

	// Pull one whole cell and compare every byte; the scrambler model follows the payload
	task automatic pull_cell(input logic [31:0] hdr, input logic [7:0] pb, input bit inc,
		input logic asg);
		logic [7:0] d, crc;
		logic s;
		crc = 8'h00;
		for (int j = 31; j >= 0; j--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ hdr[j]) ? 8'h07 : 8'h00);
		for (int i = 0; i < CELL_BYTES; i++)
		begin
			@(posedge clk);
			line_byte_req <= 1'b1;
			@(posedge clk);
			line_byte_req <= 1'b0;
			#1;
			d = (i < 4) ? hdr[31 - 8 * i -: 8] : (i == 4) ? (crc ^ 8'h55) :
				(inc ? pb + 8'(i - 5) : pb);
			for (int j = 7; j >= 0 && i > 4 && scr_on; j--)
			begin
				s = d[j] ^ scr[42];
				d[j] = s;
				scr = {scr[41:0], s};
			end
			check("line_byte", line_byte, d);
			check("line_byte_valid", line_byte_valid, 1'b1);
			check("line_cell_start", line_cell_start, i == 0);
			check("line_cell_assigned", line_cell_assigned, asg);
		end
		@(posedge clk);
		#1;
		check("h4_offset", h4_offset, 0);
	endtask

	initial
	begin
		#200000;
		error_cnt++;
		final_report();
	end

	initial
	begin
		resetn = 1'b0;
		go = 1'b0;
		base = 8'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		line_byte_req = 1'b0;
		gfc_serial_in = 1'b0;
		gfc_frame_pulse = 1'b0;
		scr = '0;
		scr_on = 1'b1;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge tx_fifo_clock);
		// Reset values, unmapped and read-only places
		rchk(ADDR_MASTER_CFG, REG_RESET);
		for (int a = 8'h60; a <= 8'h67; a++)
			rchk(8'(a), REG_RESET);
		check("tx_cell_available", tx_cell_available, 1'b1);
		reg_write(8'h70, 8'hff);
		rchk(8'h70, 8'h00);
		reg_write(ADDR_CNT_LOW, 8'hff);
		rchk(ADDR_CNT_LOW, 8'h00);
		reg_write(ADDR_CTRL_STATUS, 8'h03);
		rchk(ADDR_CTRL_STATUS, 8'h02);
		reg_write(ADDR_IDLE_HDR, 8'h3a);
		rchk(ADDR_IDLE_HDR, 8'h3a);
		reg_write(ADDR_IDLE_PAYLOAD, 8'h6b);
		rchk(ADDR_IDLE_PAYLOAD, 8'h6b);
		// Back-to-back idle cells, then one assigned cell and the counter snapshot
		pull_cell(32'h3000000a, 8'h6b, 0, 1'b0);
		pull_cell(32'h3000000a, 8'h6b, 0, 1'b0);
		send_cell(8'h21);
		pull_cell(32'h21222324, 8'h26, 1, 1'b1);
		reg_write(ADDR_MASTER_RESET, 8'h00);
		rchk(ADDR_CNT_LOW, 8'h01);
		rchk(ADDR_CNT_MID, 8'h00);
		rchk(ADDR_CNT_HIGH, 8'h00);
		// Fill all four buffers, then overrun with a fifth cell
		for (int k = 0; k < 4; k++)
			send_cell(8'h40 + 8'(k * 16));
		check("tx_cell_available", tx_cell_available, 1'b0);
		send_cell(8'hc0);
		check("tx_irq", tx_irq, 1'b1);
		rchk(ADDR_CTRL_STATUS, 8'h03);
		rchk(ADDR_CTRL_STATUS, 8'h02);
		check("tx_irq", tx_irq, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			base = 8'h40 + 8'(k * 16);
			pull_cell({base, base + 8'h01, base + 8'h02, base + 8'h03}, base + 8'h05, 1, 1'b1);
			repeat (4) @(posedge tx_fifo_clock);
			check("tx_cell_available", tx_cell_available, 1'b1);
		end
		pull_cell(32'h3000000a, 8'h6b, 0, 1'b0);
		// Depth of one cell
		reg_write(ADDR_FIFO_CFG, 8'h01);
		send_cell(8'h80);
		check("tx_cell_available", tx_cell_available, 1'b0);
		pull_cell(32'h80818283, 8'h85, 1, 1'b1);
		// Early drop: availability falls four octets before the cell ends
		reg_write(ADDR_FIFO_CFG, 8'h05);
		repeat (4) @(posedge tx_fifo_clock);
		@(posedge tx_fifo_clock);
		go <= 1'b1;
		base <= 8'h90;
		@(posedge tx_fifo_clock);
		go <= 1'b0;
		repeat (51) @(posedge tx_fifo_clock);
		#1;
		check("tx_cell_available", tx_cell_available, 1'b0);
		for (int k = 0; k < 10 && busy; k++)
			@(posedge tx_fifo_clock);
		repeat (8) @(posedge clk);
		pull_cell(32'h90919293, 8'h95, 1, 1'b1);
		// Inverted availability on an empty FIFO
		reg_write(ADDR_MASTER_CFG, 8'h08);
		repeat (4) @(posedge tx_fifo_clock);
		check("tx_cell_available", tx_cell_available, 1'b0);
		reg_write(ADDR_MASTER_CFG, 8'h00);
		// Serial GFC on bits 0 and 2 only, the rest from the idle header
		reg_write(ADDR_IDLE_HDR, 8'h0a);
		reg_write(ADDR_FIFO_CFG, 8'h50);
		@(posedge clk);
		gfc_serial_in <= 1'b1;
		gfc_frame_pulse <= 1'b1;
		@(posedge clk);
		gfc_frame_pulse <= 1'b0;
		repeat (12) @(posedge clk);
		pull_cell(32'h5000000a, 8'h6b, 0, 1'b0);
		gfc_serial_in <= 1'b0;
		reg_write(ADDR_FIFO_CFG, 8'h00);
		// Scrambler switched off leaves the payload plain
		reg_write(ADDR_CELL_CFG, 8'h01);
		scr_on = 1'b0;
		pull_cell(32'h0000000a, 8'h6b, 0, 1'b0);
		final_report();
	end
endmodule
